// [hdl/ipcd_pkg.sv]
// Functional notes
// - Program enable (AC then 53) must be the first command; no load, write, erase or parallel enable acts before it.
// - Parallel enable (AC then 35) switches to byte-parallel until programming mode ends.
// - Code page write 50, write with auto-erase 70, read 30; 9-bit page, half, byte.
// - Data page write D0, auto-erase D2, read B0; page field narrower than code.
// - User fuse write E1, auto-erase F1, read 61; zero high byte, 6-bit index.
// - Lock bits write E4, read 64; one bit per byte, data only 00h or FFh.
// - User signature write 52, auto-erase 72, read 32; low byte holds half and index.
// - Opcode 38 returns bytes of the factory identification signature page.
// - Opcode 60 shifts out the status byte; both address bytes ignored.
// - Page, fuse, lock and signature commands move 1 to 64 bytes; index advances.
// - Load page buffer (51) fills the buffer and clears load flag bit 3.
// - Success flag bit 2 clears at cycle start, sets only if no brownout occurred.
// - Write-inhibit flag bit 1 is low while the brownout detector blocks programming.
// - Busy flag bit 0 is low while programming or inhibited; bits 7..4 unused.
// - While programming, reading the last written byte returns it with MSB inverted.
// - During erase the polled value is FFh, so polling reads return 7Fh.
// - Polling reference is the last data byte loaded, not highest page address.
// - Command completes and executes only when slave select returns high.
// - Byte index passing the end of a half page wraps within that half page.
// - Bytes travel MSB first in clock mode 0, sample rising, change falling.
package ipcd_pkg;
    localparam logic [7:0] OP_ENABLE = 8'hac;
    localparam logic [7:0] SUB_PROG_EN = 8'h53;
    localparam logic [7:0] SUB_PAR_EN = 8'h35;
    localparam logic [7:0] OP_ERASE = 8'h8a;
    localparam logic [7:0] OP_STATUS = 8'h60;
    localparam logic [7:0] OP_LOAD = 8'h51;
    localparam logic [7:0] OP_CODE_WR = 8'h50;
    localparam logic [7:0] OP_CODE_AWR = 8'h70;
    localparam logic [7:0] OP_CODE_RD = 8'h30;
    localparam logic [7:0] OP_DATA_WR = 8'hd0;
    localparam logic [7:0] OP_DATA_AWR = 8'hd2;
    localparam logic [7:0] OP_DATA_RD = 8'hb0;
    localparam logic [7:0] OP_FUSE_WR = 8'he1;
    localparam logic [7:0] OP_FUSE_AWR = 8'hf1;
    localparam logic [7:0] OP_FUSE_RD = 8'h61;
    localparam logic [7:0] OP_LOCK_WR = 8'he4;
    localparam logic [7:0] OP_LOCK_RD = 8'h64;
    localparam logic [7:0] OP_USIG_WR = 8'h52;
    localparam logic [7:0] OP_USIG_AWR = 8'h72;
    localparam logic [7:0] OP_USIG_RD = 8'h32;
    localparam logic [7:0] OP_FSIG_RD = 8'h38;

    // Byte positions inside a frame.
    localparam logic [2:0] POS_OPCODE = 3'h2;
    localparam logic [2:0] POS_ADDR_HI = 3'h3;
    localparam logic [2:0] POS_ADDR_LO = 3'h4;
    localparam logic [2:0] POS_DATA = 3'h5;

    // Status bit positions.
    localparam int ST_LOAD = 3;
    localparam int ST_SUCCESS = 2;
    localparam int ST_WRITE_INHIBIT_FLAG = 1;
    localparam int ST_BUSY = 0;
    localparam logic LOAD_RESET = 1'b1;
    localparam logic SUCCESS_RESET = 1'b1;

    localparam logic [7:0] ERASE_POLL = 8'h7f;
    localparam logic [7:0] POLL_FLIP = 8'h80;

    localparam int BUF_AW = 7;
    localparam int BUF_DEPTH = 128;

    // Programming cycle times.
    localparam int CLK_PERIOD_PS = 5000;
    localparam longint T_WR_PS = 64'd2500000000;
    localparam longint T_AWR_PS = 64'd5000000000;
    localparam longint T_ERS_PS = 64'd7500000000;
    localparam int WR_CYCLES = int'((T_WR_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int AWR_CYCLES =
        int'((T_AWR_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int ERS_CYCLES =
        int'((T_ERS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int TMR_W = 23;

    typedef enum logic [2:0] {
        SP_CODE = 3'b000,
        SP_DATA = 3'b001,
        SP_FUSE = 3'b010,
        SP_LOCK = 3'b011,
        SP_USIG = 3'b100,
        SP_FSIG = 3'b101
    } ipcd_space_e;

    typedef enum logic [1:0] {
        PK_WRITE = 2'b00,
        PK_AUTO = 2'b01,
        PK_ERASE = 2'b10
    } ipcd_kind_e;
endpackage : ipcd_pkg

// [hdl/ipcd_buf_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface ipcd_buf_if;
    import ipcd_pkg::*;
    logic we;
    logic [BUF_AW-1:0] waddr;
    logic [7:0] wdata;
    logic [BUF_AW-1:0] raddr;
    logic [7:0] rdata;
    modport writer (output we, output waddr, output wdata);
    modport store (input we, input waddr, input wdata, input raddr,
        output rdata);
endinterface : ipcd_buf_if
`default_nettype wire

// [hdl/ipcd_page_buf.sv]
`timescale 1ns/100ps
`default_nettype none
module ipcd_page_buf
    import ipcd_pkg::*;
(
    input wire logic clk,
    ipcd_buf_if.store bus
);
    logic [7:0] mem_q [BUF_DEPTH];
    logic [7:0] rdata_q;

    always_ff @(posedge clk) begin
        if (bus.we) begin
            mem_q[bus.waddr] <= bus.wdata;
        end
        rdata_q <= mem_q[bus.raddr];
    end

    assign bus.rdata = rdata_q;
endmodule : ipcd_page_buf
`default_nettype wire

// [hdl/ipcd_top.sv]
`timescale 1ns/100ps
`default_nettype none
module ipcd_top
    import ipcd_pkg::*;
#(
    parameter int WR_CYC = WR_CYCLES,
    parameter int AWR_CYC = AWR_CYCLES,
    parameter int ERS_CYC = ERS_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic isp_mode,
    input wire logic sck,
    input wire logic ss_n,
    input wire logic mosi,
    output logic miso_o,
    output logic miso_oe,
    input wire logic [7:0] pdata_i,
    output logic [7:0] pdata_o,
    output logic pdata_oe,
    input wire logic brownout_detector,
    output logic nvm_start,
    output logic [1:0] nvm_kind,
    output logic [2:0] nvm_space,
    output logic [15:0] nvm_addr,
    input wire logic [BUF_AW-1:0] nvm_buf_addr,
    output logic [7:0] nvm_buf_data,
    output logic [2:0] nvm_rd_space,
    output logic [15:0] nvm_rd_addr,
    input wire logic [7:0] nvm_rd_data
);
    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [12:0] s1_q;
    logic [12:0] s2_q;
    logic sck_prev_q;
    logic ss_prev_q;

    always_ff @(posedge clk) begin
        s1_q <= {isp_mode, sck, ss_n, mosi, brownout_detector, pdata_i};
        s2_q <= s1_q;
        sck_prev_q <= s2_q[11];
        ss_prev_q <= s2_q[10];
    end

    wire mode_s = s2_q[12];
    wire sck_s = s2_q[11];
    wire ss_s = s2_q[10];
    wire mosi_s = s2_q[9];
    wire bod_s = s2_q[8];
    wire [7:0] pin_s = s2_q[7:0];
    wire in_frame = !ss_s && mode_s;
    wire sck_rise = sck_s && !sck_prev_q && in_frame;
    wire sck_fall = !sck_s && sck_prev_q && in_frame;
    wire frame_end = ss_s && !ss_prev_q && mode_s;
    wire frame_begin = !ss_s && ss_prev_q;

    // ************************************************************
    // Byte assembly
    // ************************************************************
    logic parallel_q;
    logic enabled_q;
    logic [2:0] bit_cnt_q;
    logic [6:0] rx_sh_q;
    logic [2:0] pos_q;
    logic [7:0] op_q;
    logic [7:0] ah_q;
    logic [7:0] al_q;
    logic [5:0] idx_q;
    logic [6:0] nbytes_q;

    // Parallel mode takes a whole byte per clock; serial needs eight.
    wire byte_done = sck_rise && (parallel_q || bit_cnt_q == 3'h7);
    wire [7:0] rx_byte = parallel_q ? pin_s : {rx_sh_q, mosi_s};
    wire at_data = pos_q == POS_DATA;

    always_ff @(posedge clk) begin
        if (rst || frame_begin) begin
            bit_cnt_q <= '0;
            pos_q <= '0;
            nbytes_q <= '0;
        end else if (sck_rise) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            rx_sh_q <= rx_byte[6:0];
            if (byte_done && !at_data) begin
                pos_q <= pos_q + 3'h1;
            end
            if (byte_done && at_data && nbytes_q != 7'h40) begin
                nbytes_q <= nbytes_q + 7'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            op_q <= '0;
            ah_q <= '0;
            al_q <= '0;
            idx_q <= '0;
        end else if (byte_done) begin
            case (pos_q)
                POS_OPCODE: op_q <= rx_byte;
                POS_ADDR_HI: ah_q <= rx_byte;
                POS_ADDR_LO: begin
                    al_q <= rx_byte;
                    idx_q <= rx_byte[5:0];
                end
                // The six-bit index rolls over inside the same half page.
                POS_DATA: idx_q <= idx_q + 6'h1;
                default: idx_q <= idx_q;
            endcase
        end
    end

    // ************************************************************
    // Opcode decode
    // ************************************************************
    wire is_code_wr = op_q == OP_CODE_WR;
    wire is_code_awr = op_q == OP_CODE_AWR;
    wire is_data_wr = op_q == OP_DATA_WR;
    wire is_data_awr = op_q == OP_DATA_AWR;
    wire is_fuse_wr = op_q == OP_FUSE_WR;
    wire is_fuse_awr = op_q == OP_FUSE_AWR;
    wire is_lock_wr = op_q == OP_LOCK_WR;
    wire is_usig_wr = op_q == OP_USIG_WR;
    wire is_usig_awr = op_q == OP_USIG_AWR;
    wire is_load = op_q == OP_LOAD;
    wire is_status = op_q == OP_STATUS;
    wire is_erase = op_q == OP_ERASE;
    wire is_auto = is_code_awr || is_data_awr || is_fuse_awr || is_usig_awr;
    wire is_plain = is_code_wr || is_data_wr || is_fuse_wr || is_lock_wr
        || is_usig_wr;
    wire is_mem_wr = is_auto || is_plain;
    wire is_prog_en = op_q == OP_ENABLE && ah_q == SUB_PROG_EN;
    wire is_par_en = op_q == OP_ENABLE && ah_q == SUB_PAR_EN;

    logic [2:0] space_w;
    assign space_w =
        (op_q == OP_DATA_RD || is_data_wr || is_data_awr) ? SP_DATA :
        (op_q == OP_FUSE_RD || is_fuse_wr || is_fuse_awr) ? SP_FUSE :
        (op_q == OP_LOCK_RD || is_lock_wr) ? SP_LOCK :
        (op_q == OP_USIG_RD || is_usig_wr || is_usig_awr) ? SP_USIG :
        (op_q == OP_FSIG_RD) ? SP_FSIG : SP_CODE;

    // Page buffer address is the half select and the running index.
    wire [BUF_AW-1:0] buf_addr = {al_q[6], idx_q};
    wire [15:0] cur_addr = {ah_q, al_q[7:6], idx_q};
    wire accept_data = enabled_q && (is_mem_wr || is_load);
    wire data_wr = byte_done && at_data && accept_data;

    ipcd_buf_if buf_bus ();
    assign buf_bus.we = data_wr;
    assign buf_bus.waddr = buf_addr;
    assign buf_bus.wdata = rx_byte;
    assign buf_bus.raddr = nvm_buf_addr;
    assign nvm_buf_data = buf_bus.rdata;

    ipcd_page_buf u_buf (
        .clk(clk),
        .bus(buf_bus)
    );

    // ************************************************************
    // Command execution on the closing select edge
    // ************************************************************
    logic load_q;
    logic pend_q;
    logic [1:0] pend_kind_q;
    logic [2:0] pend_space_q;
    logic [15:0] pend_addr_q;
    logic [7:0] poll_val_q;
    logic [2:0] poll_space_q;
    logic [15:0] poll_addr_q;
    logic prog_q;
    logic erase_q;
    logic bod_seen_q;
    logic success_q;
    logic [TMR_W-1:0] tmr_q;

    wire exec = frame_end && enabled_q;
    wire exec_wr = exec && is_mem_wr && nbytes_q != 7'h0;
    wire exec_er = exec && is_erase && pos_q >= POS_ADDR_HI;

    always_ff @(posedge clk) begin
        if (rst || !mode_s) begin
            enabled_q <= 1'b0;
            parallel_q <= 1'b0;
        end else if (frame_end && pos_q >= POS_ADDR_LO) begin
            if (is_prog_en) begin
                enabled_q <= 1'b1;
            end
            if (is_par_en && enabled_q) begin
                parallel_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            load_q <= LOAD_RESET;
        end else if (exec && is_load) begin
            load_q <= 1'b0;
        end else if (exec_wr) begin
            load_q <= 1'b1;
        end
    end

    // The last loaded byte is the polling reference.
    always_ff @(posedge clk) begin
        if (rst) begin
            poll_val_q <= '0;
        end else if (data_wr) begin
            poll_val_q <= rx_byte;
        end
    end

    // A command arriving during a cycle waits here until it ends.
    wire start = pend_q && !prog_q && !bod_s;

    always_ff @(posedge clk) begin
        if (rst) begin
            pend_q <= 1'b0;
            pend_kind_q <= PK_WRITE;
            pend_space_q <= SP_CODE;
            pend_addr_q <= '0;
        end else if (exec_wr || exec_er) begin
            pend_q <= 1'b1;
            pend_kind_q <= exec_er ? PK_ERASE : is_auto ? PK_AUTO : PK_WRITE;
            pend_space_q <= space_w;
            pend_addr_q <= {ah_q, al_q[7:6], 6'h00};
        end else if (start) begin
            pend_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            poll_space_q <= SP_CODE;
            poll_addr_q <= '0;
        end else if (exec_wr) begin
            poll_space_q <= space_w;
            poll_addr_q <= {ah_q, al_q[7:6], idx_q - 6'h1};
        end
    end

    // ************************************************************
    // Programming cycle timer
    // ************************************************************
    logic [TMR_W-1:0] cyc_len;
    assign cyc_len = (pend_kind_q == PK_ERASE) ? TMR_W'(ERS_CYC - 1) :
        (pend_kind_q == PK_AUTO) ? TMR_W'(AWR_CYC - 1) :
        TMR_W'(WR_CYC - 1);

    always_ff @(posedge clk) begin
        if (rst) begin
            prog_q <= 1'b0;
            erase_q <= 1'b0;
            tmr_q <= '0;
        end else if (start) begin
            prog_q <= 1'b1;
            erase_q <= pend_kind_q == PK_ERASE;
            tmr_q <= cyc_len;
        end else if (prog_q) begin
            tmr_q <= tmr_q - TMR_W'(1);
            if (tmr_q == '0) begin
                prog_q <= 1'b0;
                erase_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            success_q <= SUCCESS_RESET;
            bod_seen_q <= 1'b0;
        end else if (start) begin
            success_q <= 1'b0;
            bod_seen_q <= 1'b0;
        end else if (prog_q) begin
            if (bod_s) begin
                bod_seen_q <= 1'b1;
            end
            if (tmr_q == '0) begin
                success_q <= !bod_seen_q && !bod_s;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            nvm_start <= 1'b0;
            nvm_kind <= PK_WRITE;
            nvm_space <= SP_CODE;
            nvm_addr <= '0;
        end else begin
            nvm_start <= start;
            if (start) begin
                nvm_kind <= pend_kind_q;
                nvm_space <= pend_space_q;
                nvm_addr <= pend_addr_q;
            end
        end
    end

    // ************************************************************
    // Status and read data
    // ************************************************************
    logic [7:0] status_w;
    assign status_w = {4'h0, load_q, success_q, !bod_s,
        !(prog_q || bod_s)};

    assign nvm_rd_space = space_w;
    assign nvm_rd_addr = cur_addr;

    wire poll_hit = prog_q && !erase_q && space_w == poll_space_q
        && cur_addr == poll_addr_q;
    logic [7:0] rd_w;
    assign rd_w = (prog_q && erase_q) ? ERASE_POLL :
        poll_hit ? (poll_val_q ^ POLL_FLIP) : nvm_rd_data;

    logic [7:0] tx_q;
    logic [7:0] tx_sh_q;

    // Fetched a cycle ahead; SCK half periods leave ample margin.
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_q <= '0;
        end else begin
            tx_q <= is_status ? status_w : rd_w;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_sh_q <= '0;
            miso_o <= 1'b0;
            pdata_o <= '0;
        end else if (sck_fall) begin
            if (parallel_q) begin
                pdata_o <= tx_q;
            end else if (bit_cnt_q == 3'h0) begin
                miso_o <= tx_q[7];
                tx_sh_q <= {tx_q[6:0], 1'b0};
            end else begin
                miso_o <= tx_sh_q[7];
                tx_sh_q <= {tx_sh_q[6:0], 1'b0};
            end
        end
    end

    // In parallel mode the MOSI pin becomes an active-low output enable.
    assign miso_oe = in_frame && !parallel_q;
    assign pdata_oe = in_frame && parallel_q && !mosi_s;
endmodule : ipcd_top
`default_nettype wire

// [verif/ipcd_properties.sv]
`timescale 1ns/100ps
`default_nettype none
module ipcd_properties
    import ipcd_pkg::*;
#(
    parameter int WR_CYC = 50,
    parameter int AWR_CYC = 100,
    parameter int ERS_CYC = 150
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic isp_mode,
    input wire logic sck,
    input wire logic ss_n,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe,
    input wire logic [7:0] pdata_o,
    input wire logic pdata_oe,
    input wire logic brownout_detector,
    input wire logic nvm_start,
    input wire logic [1:0] nvm_kind,
    input wire logic [2:0] nvm_space,
    input wire logic [15:0] nvm_addr
);
    // ****************************************
    // Cycle tracking and properties
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Cycles still left of the running programming cycle.
    logic [31:0] gap_q;
    logic [31:0] gap_d;
    logic [31:0] len;
    assign len = (nvm_kind == PK_ERASE) ? 32'(ERS_CYC)
        : (nvm_kind == PK_AUTO) ? 32'(AWR_CYC) : 32'(WR_CYC);
    assign gap_d = nvm_start ? len - 32'h1
        : (gap_q != 32'h0) ? gap_q - 32'h1 : 32'h0;
    always_ff @(posedge clk) begin
        if (rst) begin
            gap_q <= 32'h0;
        end else begin
            gap_q <= gap_d;
        end
    end
    sequence quiet_s;
        !nvm_start [*2];
    endsequence
    sequence sck_low_s;
        !sck ##0 !$past(sck);
    endsequence
    start_pulse_a: assert property (nvm_start |=> quiet_s)
        else $error("start pulse longer than one cycle");
    start_gap_a: assert property (nvm_start |-> gap_q == 32'h0)
        else $error("new cycle started while busy");
    start_kind_a: assert property (nvm_start |->
        nvm_kind != 2'h3 && nvm_space <= 3'h5)
        else $error("illegal cycle kind or space");
    page_align_a: assert property (nvm_start && nvm_kind != PK_ERASE |->
        nvm_addr[5:0] == 6'h0)
        else $error("cycle address not page aligned");
    fields_hold_a: assert property ($changed({nvm_kind, nvm_space,
        nvm_addr}) |-> nvm_start)
        else $error("cycle fields changed without start");
    brown_block_a: assert property (nvm_start |->
        !$past(brownout_detector, 3))
        else $error("cycle started under brownout");
    serial_oe_a: assert property (miso_oe |-> !$past(ss_n, 2)
        && $past(isp_mode, 2) && !pdata_oe)
        else $error("serial output enabled outside frame");
    par_oe_a: assert property (pdata_oe |-> !$past(ss_n, 2)
        && !$past(mosi, 2))
        else $error("parallel output enabled wrongly");
    miso_edge_a: assert property ($changed(miso_o) |-> sck_low_s)
        else $error("serial output changed with clock high");
    pdata_edge_a: assert property ($changed(pdata_o) |-> sck_low_s)
        else $error("parallel output changed with clock high");
endmodule : ipcd_properties
bind ipcd_top ipcd_properties #(.WR_CYC(WR_CYC), .AWR_CYC(AWR_CYC),
    .ERS_CYC(ERS_CYC)) ipcd_properties_i (.clk(clk), .rst(rst),
    .isp_mode(isp_mode), .sck(sck), .ss_n(ss_n), .mosi(mosi),
    .miso_o(miso_o), .miso_oe(miso_oe), .pdata_o(pdata_o),
    .pdata_oe(pdata_oe), .brownout_detector(brownout_detector),
    .nvm_start(nvm_start), .nvm_kind(nvm_kind), .nvm_space(nvm_space),
    .nvm_addr(nvm_addr));
`default_nettype wire

// [verif/ipcd_programmer.sv]
`timescale 1ns/100ps
`default_nettype none
module ipcd_programmer (
    input wire logic clk,
    input wire logic miso_o,
    input wire logic [7:0] pdata_o,
    output logic sck,
    output logic ss_n,
    output logic mosi,
    output logic [7:0] pdata_i
);
    // ****************************************
    // Programmer frame engine
    // ****************************************
    logic [7:0] tx [0:15];
    logic [7:0] rx [0:15];
    logic par;
    initial begin
        sck = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b0;
        pdata_i = 8'h00;
        par = 1'b0;
    end
    task automatic half();
        repeat (16) @(negedge clk);
    endtask : half
    // Bytes from rd_at on are read; the clock stands low between frames.
    task automatic frame(input int n, input int rd_at);
        ss_n = 1'b0;
        half();
        for (int i = 0; i < n; i++) begin
            for (int b = 7; b >= 0; b--) begin
                if (par) begin
                    mosi = (i < rd_at);
                    pdata_i = (i < rd_at) ? tx[i] : ~pdata_i;
                end else begin
                    mosi = tx[i][b];
                end
                half();
                sck = 1'b1;
                if (par) rx[i] = pdata_o;
                else rx[i][b] = miso_o;
                half();
                sck = 1'b0;
                if (par) break;
            end
        end
        ss_n = 1'b1;
        mosi = ~mosi;
        pdata_i = ~pdata_i;
        half();
        half();
    endtask : frame
endmodule : ipcd_programmer
`default_nettype wire

// [verif/tb_isp_programming_command_decoder.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_isp_programming_command_decoder
    import ipcd_pkg::*;
;
    localparam int WRC = 3400;
    localparam int AWRC = 3600;
    localparam int ERSC = 3800;
    localparam logic [7:0] WOP [8] = '{OP_CODE_AWR, OP_DATA_WR, OP_DATA_AWR,
        OP_FUSE_WR, OP_FUSE_AWR, OP_LOCK_WR, OP_USIG_WR, OP_USIG_AWR};
    localparam logic [2:0] WSP [8] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3,
        3'h4, 3'h4};
    localparam logic [7:0] AUTO = 8'h95;
    localparam logic [7:0] ROP [6] = '{OP_CODE_RD, OP_DATA_RD, OP_FUSE_RD,
        OP_LOCK_RD, OP_USIG_RD, OP_FSIG_RD};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic isp_mode = 1'b1;
    logic brownout_detector = 1'b0;
    logic sck, ss_n, mosi, miso_o, miso_oe, pdata_oe, nvm_start;
    logic [7:0] pdata_i, pdata_o, nvm_buf_data, nvm_rd_data, ah, al, last;
    logic [1:0] nvm_kind;
    logic [2:0] nvm_space, nvm_rd_space;
    logic [15:0] nvm_addr, nvm_rd_addr;
    logic [BUF_AW-1:0] nvm_buf_addr = '0;
    int seed = 60;
    int n_fail = 0;
    int check_count = 0;
    int starts = 0;
    // ****************************************
    // Models and tasks
    // ****************************************
    function automatic logic [7:0] rd_model(logic [2:0] sp, logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ {sp, 5'h15};
    endfunction : rd_model
    function automatic logic [15:0] amask(logic [2:0] sp);
        case (sp)
            3'h0: return 16'hffff;
            3'h1: return 16'h1fff;
            3'h2, 3'h3: return 16'h003f;
            3'h5: return 16'h007f;
            default: return 16'h00ff;
        endcase
    endfunction : amask
    assign nvm_rd_data = rd_model(nvm_rd_space, nvm_rd_addr);
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) if (nvm_start === 1'b1) starts <= starts + 1;
    task automatic chk(input string what, input logic [15:0] e,
        input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic hdr(input logic [7:0] op, input int n);
        ipcd_programmer_i.tx[0] = 8'h00;
        ipcd_programmer_i.tx[1] = 8'h00;
        ipcd_programmer_i.tx[2] = op;
        ipcd_programmer_i.tx[3] = ah;
        ipcd_programmer_i.tx[4] = al;
        for (int i = 0; i < n; i++) begin
            last = 8'($random(seed));
            if (op == OP_LOCK_WR) last = {8{last[0]}};
            ipcd_programmer_i.tx[5 + i] = last;
        end
    endtask : hdr
    task automatic wr(input logic [7:0] op, input int n, input int ns,
        input logic [1:0] k, input logic [2:0] sp);
        int s0;
        s0 = starts;
        hdr(op, n);
        ipcd_programmer_i.frame(5 + n, 16);
        chk("start count", 16'(s0 + ns), 16'(starts));
        if (ns > 0) begin
            chk("kind", 16'(k), 16'(nvm_kind));
            chk("space", 16'(sp), 16'(nvm_space));
            if (k != PK_ERASE) chk("addr", {ah, al[7:6], 6'h0}, nvm_addr);
        end
    endtask : wr
    task automatic rd(input logic [7:0] op, input int n);
        hdr(op, n);
        ipcd_programmer_i.frame(5 + n, 5);
    endtask : rd
    task automatic stat(input logic [7:0] e);
        hdr(OP_STATUS, 1);
        ipcd_programmer_i.tx[3] = 8'($random(seed));
        ipcd_programmer_i.tx[4] = 8'($random(seed));
        ipcd_programmer_i.frame(6, 5);
        chk("status", 16'(e), 16'(ipcd_programmer_i.rx[5]));
    endtask : stat
    task automatic idle(input logic [1:0] k);
        repeat ((k == PK_ERASE ? ERSC : k == PK_AUTO ? AWRC : WRC) + 50)
            @(negedge clk);
    endtask : idle
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_of_test
    ipcd_programmer ipcd_programmer_i (.clk(clk), .miso_o(miso_o),
        .pdata_o(pdata_o), .sck(sck), .ss_n(ss_n), .mosi(mosi),
        .pdata_i(pdata_i));
    ipcd_top #(.WR_CYC(WRC), .AWR_CYC(AWRC), .ERS_CYC(ERSC)) ipcd_top_i (
        .clk(clk), .rst(rst), .isp_mode(isp_mode), .sck(sck), .ss_n(ss_n),
        .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe), .pdata_i(pdata_i),
        .pdata_o(pdata_o), .pdata_oe(pdata_oe),
        .brownout_detector(brownout_detector), .nvm_start(nvm_start),
        .nvm_kind(nvm_kind), .nvm_space(nvm_space), .nvm_addr(nvm_addr),
        .nvm_buf_addr(nvm_buf_addr), .nvm_buf_data(nvm_buf_data),
        .nvm_rd_space(nvm_rd_space), .nvm_rd_addr(nvm_rd_addr),
        .nvm_rd_data(nvm_rd_data));
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        repeat (8) @(negedge clk);
        {ah, al} = 16'h123e;
        wr(OP_CODE_WR, 2, 0, PK_WRITE, SP_CODE);
        hdr(OP_ENABLE, 0);
        ipcd_programmer_i.tx[3] = SUB_PROG_EN;
        ipcd_programmer_i.frame(5, 16);
        stat(8'h0f);
        wr(8'hff, 2, 0, PK_WRITE, SP_CODE);
        wr(OP_LOAD, 3, 0, PK_WRITE, SP_CODE);
        stat(8'h07);
        $display("test enable and load finished");
        ah = 8'($random(seed));
        al = {2'($random(seed)), 6'h3e};
        wr(OP_CODE_WR, 4, 1, PK_WRITE, SP_CODE);
        for (int i = 0; i < 4; i++) begin
            nvm_buf_addr = {al[6], 6'(al[5:0] + 6'(i))};
            repeat (2) @(negedge clk);
            chk("buffer", 16'(ipcd_programmer_i.tx[5 + i]), 16'(nvm_buf_data));
        end
        stat(8'h0a);
        al[5:0] = 6'h01;
        rd(OP_CODE_RD, 1);
        chk("poll", 16'(ipcd_programmer_i.tx[8] ^ 8'h80), 16'(ipcd_programmer_i.rx[5]));
        idle(PK_WRITE);
        rd(OP_CODE_RD, 1);
        chk("true read", 16'(rd_model(SP_CODE, {ah, al})), 16'(ipcd_programmer_i.rx[5]));
        stat(8'h0f);
        $display("test page write finished");
        for (int i = 0; i < 8; i++) begin
            {ah, al} = 16'($random(seed)) & amask(WSP[i]);
            wr(WOP[i], 1, 1, {1'b0, AUTO[i]}, WSP[i]);
            idle({1'b0, AUTO[i]});
        end
        for (int i = 0; i < 6; i++) begin
            {ah, al} = 16'($random(seed)) & amask(3'(i));
            rd(ROP[i], 2);
            for (int j = 0; j < 2; j++)
                chk("read", 16'(rd_model(3'(i), {ah, al[7:6], 6'(al[5:0] + 6'(j))})), 16'(ipcd_programmer_i.rx[5 + j]));
        end
        $display("test spaces finished");
        wr(OP_ERASE, 0, 1, PK_ERASE, SP_CODE);
        rd(OP_DATA_RD, 1);
        chk("erase poll", 16'h007f, 16'(ipcd_programmer_i.rx[5]));
        idle(PK_ERASE);
        wr(OP_CODE_WR, 1, 1, PK_WRITE, SP_CODE);
        brownout_detector = 1'b1;
        repeat (10) @(negedge clk);
        stat(8'h08);
        brownout_detector = 1'b0;
        idle(PK_WRITE);
        stat(8'h0b);
        $display("test erase and brownout finished");
        hdr(OP_ENABLE, 0);
        ipcd_programmer_i.tx[3] = SUB_PAR_EN;
        ipcd_programmer_i.frame(5, 16);
        ipcd_programmer_i.par = 1'b1;
        stat(8'h0b);
        $display("test parallel finished");
        end_of_test();
    end
    initial begin
        repeat (98000) @(posedge clk);
        n_fail++;
        end_of_test();
    end
endmodule : tb_isp_programming_command_decoder
`default_nettype wire
